// ---- verilog/iobs_pkg.sv ----
// constants for the board strap, decode and interrupt routing block
// Behaviour
// - select when A7..A3 match paddles two-six
// - wait paddle adds wait on selected cycles
// - handshake latch sets on falling strobe when off
// - base plus one returns baud paddles
// - loopback copies read input into output
// - only master controller answers acknowledge cycles
// - master drives PINT, slave drives vectored line
// - request inputs zero-two tie to lines zero-two
// - reset contact resets CPU and bus slaves
// - higher request still preempts one in service
// - equal or lower blocked until end command
package iobs_pkg;
    // register byte offsets on the register bus
    localparam logic [7:0] ADDR_SW_OFS = 8'h00;
    localparam logic [7:0] BAUD_SW_OFS = 8'h04;
    localparam logic [7:0] STRAP_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    // reset values: factory switch and jumper setting
    localparam logic [7:0] ADDR_SW_RST = 8'h1b;
    localparam logic [7:0] BAUD_SW_RST = 8'h2f;
    localparam logic [7:0] STRAP_RST = 8'h06;
    // address switch fields (bit n is paddle n+1)
    localparam int WAIT_BIT = 0;
    localparam int BASE_LSB = 1;
    localparam int POL0_BIT = 6;
    localparam int POL1_BIT = 7;
    // strap register fields
    localparam int LOOP_BIT = 0;
    localparam int MASTER_BIT = 1;
    localparam int DRIVE_BIT = 2;
    localparam int VLINE_LSB = 4;
    // baud port: paddles one to six wired, seven and eight open
    localparam logic [7:0] BAUD_WIRED = 8'h3f;
    // status register fields
    localparam int ST_ISR_LSB = 8;
    localparam int ST_CONTROLLER_REQUEST_OUTPUT_BIT = 16;
    localparam int ST_HS_LSB = 17;
    // board port offsets from base, bank zero
    localparam logic [2:0] P_HS = 3'h0;
    localparam logic [2:0] P_BAUD = 3'h1;
    localparam logic [2:0] P_AUX = 3'h3;
    localparam logic [2:0] P_MASK = 3'h5;
    localparam logic [2:0] P_EOS = 3'h6;
    localparam logic [2:0] P_BANK = 3'h7;
    localparam logic [2:0] BANK_ZERO = 3'h0;
    // interrupt vector upper bits, arbitrary value
    localparam logic [4:0] VEC_HI_RST = 5'h1f;
    localparam logic [2:0] IDLE_VEC = 3'h7;
endpackage

// ---- verilog/iobs_top.sv ----
// board strap, port decode, handshake and interrupt routing logic
module iobs_top #(
    parameter int NREQ = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] bus_addr,
    input wire logic bus_io_rd,
    input wire logic bus_io_wr,
    input wire logic bus_inta,
    input wire logic [7:0] bus_dout,
    output logic [7:0] bus_din_q,
    output logic board_sel_q,
    output logic wait_req_q,
    input wire logic [7:0] aux_in,
    input wire logic [1:0] aux_stb,
    output logic [7:0] aux_out_q,
    output logic [1:0] hs_latch_q,
    input wire logic [2:0] vi_req,
    input wire logic [NREQ-1:3] board_req,
    output logic pint_oe_q,
    output logic [7:0] vi_oe_q,
    output logic controller_request_output,
    input wire logic reset_contact_input,
    output logic cpu_reset_q,
    output logic slave_reset_q
);
    // register bus state
    logic [7:0] addr_sw_q, addr_sw_d;
    logic [7:0] baud_sw_q, baud_sw_d;
    logic [7:0] strap_q, strap_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] waddr_q, waddr_d;
    logic [31:0] hrdata_q, hrdata_d;
    // board port state
    logic sel_q, sel_d, wait_q, wait_d;
    logic [7:0] din_q, din_d, aux_out_d, aux_in_q, aux_in_d;
    logic [1:0] hs_q, hs_d, stb_q;
    logic [2:0] bank_q, bank_d;
    logic rst_c_q, rst_s_q;
    // controller state
    logic [NREQ-1:0] irr_q, mask_q, mask_d, isr_q, isr_d, elig;
    logic controller_request_output_q, controller_request_output_d, pint_q, pint_d;
    logic [7:0] vi_q, vi_d;
    logic [2:0] top_idx;
    logic top_any;
    logic [NREQ-1:0] block;
    // decode helpers
    logic match, io_cyc, in_bank0, eos_wr, ack;
    logic [1:0] stb_edge;

    // address phase taken only with the bus ready and a real transfer
    always_comb begin
        wr_pend_d = hsel & htrans[1] & hready & hwrite;
        waddr_d = wr_pend_d ? haddr[7:0] : waddr_q;
        addr_sw_d = addr_sw_q;
        baud_sw_d = baud_sw_q;
        strap_d = strap_q;
        hrdata_d = 32'h0000_0000;
        if (wr_pend_q) begin
            case (waddr_q)
                iobs_pkg::ADDR_SW_OFS: addr_sw_d = hwdata[7:0];
                iobs_pkg::BAUD_SW_OFS: baud_sw_d = hwdata[7:0];
                iobs_pkg::STRAP_OFS: strap_d = hwdata[7:0];
                default: ;
            endcase
        end
        // read data registered one cycle early, unmapped reads zero
        if (hsel & htrans[1] & hready & ~hwrite) begin
            case (haddr[7:0])
                iobs_pkg::ADDR_SW_OFS: hrdata_d[7:0] = addr_sw_q;
                iobs_pkg::BAUD_SW_OFS: hrdata_d[7:0] = baud_sw_q;
                iobs_pkg::STRAP_OFS: hrdata_d[7:0] = strap_q;
                iobs_pkg::STATUS_OFS: begin
                    hrdata_d[7:0] = irr_q;
                    hrdata_d[iobs_pkg::ST_ISR_LSB +: 8] = isr_q;
                    hrdata_d[iobs_pkg::ST_CONTROLLER_REQUEST_OUTPUT_BIT] = controller_request_output_q;
                    hrdata_d[iobs_pkg::ST_HS_LSB +: 2] = hs_q;
                end
                default: hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_sw_q <= iobs_pkg::ADDR_SW_RST;
            baud_sw_q <= iobs_pkg::BAUD_SW_RST;
            strap_q <= iobs_pkg::STRAP_RST;
            wr_pend_q <= 1'b0;
            waddr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            addr_sw_q <= addr_sw_d;
            baud_sw_q <= baud_sw_d;
            strap_q <= strap_d;
            wr_pend_q <= wr_pend_d;
            waddr_q <= waddr_d;
            hrdata_q <= hrdata_d;
        end
    end

    // zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // highest pending request not blocked by anything in service
    always_comb begin
        block = '0;
        for (int i = 1; i < NREQ; i++) begin
            block[i] = block[i-1] | isr_q[i-1];
        end
        // a request at or below the top in-service level stays blocked
        elig = irr_q & ~mask_q & ~block & ~isr_q;
        top_any = |elig;
        top_idx = iobs_pkg::IDLE_VEC;
        for (int i = NREQ - 1; i >= 0; i--) begin
            if (elig[i]) begin
                top_idx = 3'(i);
            end
        end
    end

    // port decode: base on A7..A3, eight ports below it
    always_comb begin
        match = 1'b1;
        for (int i = 0; i < 5; i++) begin
            // paddle on means the address bit reads zero
            if (bus_addr[7-i] == addr_sw_q[iobs_pkg::BASE_LSB + i]) begin
                match = 1'b0;
            end
        end
        io_cyc = bus_io_rd | bus_io_wr;
        in_bank0 = bank_q == iobs_pkg::BANK_ZERO;
        ack = bus_inta & strap_q[iobs_pkg::MASTER_BIT];
        eos_wr = io_cyc & match & bus_io_wr & in_bank0 &
                 bus_addr[2:0] == iobs_pkg::P_EOS;
        // latch edge polarity per paddle
        stb_edge[0] = addr_sw_q[iobs_pkg::POL0_BIT] ?
                      (aux_stb[0] & ~stb_q[0]) :
                      (~aux_stb[0] & stb_q[0]);
        stb_edge[1] = addr_sw_q[iobs_pkg::POL1_BIT] ?
                      (aux_stb[1] & ~stb_q[1]) :
                      (~aux_stb[1] & stb_q[1]);
    end

    // board ports: select, wait, data returned, aux latches
    always_comb begin
        sel_d = io_cyc & match;
        wait_d = addr_sw_q[iobs_pkg::WAIT_BIT] & (sel_d | ack);
        din_d = 8'h00;
        aux_out_d = aux_out_q;
        aux_in_d = stb_edge[0] ? aux_in : aux_in_q;
        hs_d = hs_q | stb_edge;
        bank_d = bank_q;
        if (sel_d & bus_io_rd) begin
            case (bus_addr[2:0])
                iobs_pkg::P_HS: din_d = in_bank0 ? {6'h00, hs_q} : 8'h00;
                iobs_pkg::P_BAUD: begin
                    if (in_bank0) begin
                        din_d = baud_sw_q & iobs_pkg::BAUD_WIRED;
                    end
                end
                iobs_pkg::P_AUX: begin
                    if (in_bank0) begin
                        din_d = aux_in_q;
                        // reading takes the input, the set edge wins
                        hs_d[0] = stb_edge[0];
                        if (strap_q[iobs_pkg::LOOP_BIT]) begin
                            aux_out_d = aux_in_q;
                        end
                    end
                end
                iobs_pkg::P_MASK: din_d = in_bank0 ? mask_q : 8'h00;
                iobs_pkg::P_EOS: din_d = in_bank0 ? isr_q : 8'h00;
                iobs_pkg::P_BANK: din_d = {5'h00, bank_q};
                default: din_d = 8'h00;
            endcase
        end else if (sel_d & bus_io_wr) begin
            case (bus_addr[2:0])
                iobs_pkg::P_AUX: begin
                    if (in_bank0) begin
                        aux_out_d = bus_dout;
                        hs_d[1] = stb_edge[1];
                    end
                end
                iobs_pkg::P_BANK: bank_d = bus_dout[2:0];
                default: ;
            endcase
        end else if (ack) begin
            // an empty acknowledge falls back to the lowest level
            din_d = {iobs_pkg::VEC_HI_RST, top_idx};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q <= 1'b0;
            wait_q <= 1'b0;
            din_q <= 8'h00;
            aux_out_q <= 8'h00;
            aux_in_q <= 8'h00;
            hs_q <= 2'b00;
            // history idles high so a falling strobe right after reset counts
            stb_q <= 2'b11;
            bank_q <= 3'h0;
            rst_c_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            wait_q <= wait_d;
            din_q <= din_d;
            aux_out_q <= aux_out_d;
            aux_in_q <= aux_in_d;
            hs_q <= hs_d;
            stb_q <= aux_stb;
            bank_q <= bank_d;
            rst_c_q <= reset_contact_input;
            rst_s_q <= reset_contact_input;
        end
    end

    // controller: service register, mask, request routing
    always_comb begin
        isr_d = isr_q;
        mask_d = mask_q;
        if (ack & top_any) begin
            isr_d[top_idx] = 1'b1;
        end
        if (eos_wr) begin
            // end command retires only the top level in service
            for (int i = NREQ - 1; i >= 0; i--) begin
                if (isr_q[i] & ~block[i]) begin
                    isr_d[i] = 1'b0;
                end
            end
        end
        if (sel_d & bus_io_wr & in_bank0 &
            bus_addr[2:0] == iobs_pkg::P_MASK) begin
            mask_d = bus_dout;
        end
        controller_request_output_d = top_any;
        // master routes to PINT, slave to the chosen vectored line
        pint_d = top_any & strap_q[iobs_pkg::DRIVE_BIT] &
                 strap_q[iobs_pkg::MASTER_BIT];
        vi_d = 8'h00;
        if (~strap_q[iobs_pkg::MASTER_BIT]) begin
            vi_d[strap_q[iobs_pkg::VLINE_LSB +: 3]] = top_any;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irr_q <= '0;
            isr_q <= '0;
            mask_q <= '0;
            controller_request_output_q <= 1'b0;
            pint_q <= 1'b0;
            vi_q <= 8'h00;
        end else begin
            irr_q <= {board_req, vi_req};
            isr_q <= isr_d;
            mask_q <= mask_d;
            controller_request_output_q <= controller_request_output_d;
            pint_q <= pint_d;
            vi_q <= vi_d;
        end
    end

    assign bus_din_q = din_q;
    assign board_sel_q = sel_q;
    assign wait_req_q = wait_q;
    assign hs_latch_q = hs_q;
    assign pint_oe_q = pint_q;
    assign vi_oe_q = vi_q;
    assign controller_request_output = controller_request_output_q;
    assign cpu_reset_q = rst_c_q;
    assign slave_reset_q = rst_s_q;

    // checks on decode, wait, latches and routing
    AST_SEL: assert property (@(posedge hclk) disable iff (!hresetn)
        io_cyc && bus_addr[7:3] == ~{addr_sw_q[1], addr_sw_q[2],
        addr_sw_q[3], addr_sw_q[4], addr_sw_q[5]} |=> board_sel_q)
        else $error("matched cycle not selected");
    AST_NOSEL: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_addr[7:3] != ~{addr_sw_q[1], addr_sw_q[2],
        addr_sw_q[3], addr_sw_q[4], addr_sw_q[5]} |=> !board_sel_q)
        else $error("unmatched cycle selected");
    AST_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
        board_sel_q |-> wait_req_q == $past(addr_sw_q[0]))
        else $error("wait state not following paddle");
    AST_NEGSTB: assert property (@(posedge hclk) disable iff (!hresetn)
        !addr_sw_q[6] && $fell(aux_stb[0]) |=> hs_latch_q[0])
        else $error("falling strobe missed");
    AST_POSSTB: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_sw_q[6] && hs_q[0] == 1'b0 && $fell(aux_stb[0])
        && !$stable(addr_sw_q) == 1'b0 |=> !hs_latch_q[0])
        else $error("falling strobe set rising latch");
    AST_BAUD: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_d && bus_io_rd && in_bank0 && bus_addr[2:0] == 3'h1
        |=> bus_din_q == {2'b00, $past(baud_sw_q[5:0])})
        else $error("baud port wrong");
    AST_LOOP: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_d && bus_io_rd && in_bank0 && bus_addr[2:0] == 3'h3
        && strap_q[0] |=> aux_out_q == $past(aux_in_q))
        else $error("loopback not captured");
    AST_SLAVE: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_inta && !strap_q[1] && !eos_wr |=> $stable(isr_q))
        else $error("slave answered acknowledge");
    AST_PINT: assert property (@(posedge hclk) disable iff (!hresetn)
        !strap_q[1] |=> !pint_oe_q)
        else $error("slave drove PINT");
    AST_MAP: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 irr_q[2:0] == $past(vi_req))
        else $error("request lines not mapped");
    AST_RST: assert property (@(posedge hclk) disable iff (!hresetn)
        reset_contact_input |=> cpu_reset_q && slave_reset_q)
        else $error("reset contact not fanned out");
    AST_BLOCK: assert property (@(posedge hclk) disable iff (!hresetn)
        isr_q != '0 && (irr_q & ~mask_q &
        ((isr_q & (~isr_q + 1'b1)) - 1'b1)) == '0
        |=> !controller_request_output)
        else $error("request passed top level in service");
    AST_NEST: assert property (@(posedge hclk) disable iff (!hresetn)
        ack && top_any && !eos_wr
        |=> $countones(isr_q) == $countones($past(isr_q)) + 1)
        else $error("preempting request not taken");
    AST_EOS: assert property (@(posedge hclk) disable iff (!hresetn)
        eos_wr && !ack && isr_q != '0
        |=> $countones(isr_q) == $countones($past(isr_q)) - 1)
        else $error("end command did not retire one level");
    AST_VEC: assert property (@(posedge hclk) disable iff (!hresetn)
        ack && !top_any && !io_cyc
        |=> bus_din_q == {iobs_pkg::VEC_HI_RST, iobs_pkg::IDLE_VEC})
        else $error("empty acknowledge vector wrong");
endmodule

// ---- verif/iobs_cpu_model.sv ----
// bus cpu master model: i/o read, i/o write and acknowledge cycles
module iobs_cpu_model (
    input wire logic hclk,
    output logic [7:0] bus_addr,
    output logic bus_io_rd,
    output logic bus_io_wr,
    output logic bus_inta,
    output logic [7:0] bus_dout,
    input wire logic [7:0] bus_din_q
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        bus_addr = 8'h00;
        bus_io_rd = 1'b0;
        bus_io_wr = 1'b0;
        bus_inta = 1'b0;
        bus_dout = 8'h5a;
    end
    // kind: bit0 read, bit1 write, bit2 acknowledge; one cycle pulse
    task automatic cycle(input logic [2:0] kind, input logic [7:0] a,
            input logic [7:0] d, output logic [7:0] q);
        @(posedge hclk);
        bus_addr <= a;
        bus_dout <= d;
        bus_io_rd <= kind[0];
        bus_io_wr <= kind[1];
        bus_inta <= kind[2];
        @(posedge hclk);
        bus_io_rd <= 1'b0;
        bus_io_wr <= 1'b0;
        bus_inta <= 1'b0;
        // released data must not keep its last value
        bus_dout <= ~d;
        #1;
        q = bus_din_q;
    endtask
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the strap, decode and interrupt block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0] htrans = 0, aux_stb = 2'b11, hs;
    logic [2:0] hsize = 3'h2, vi_req = 0;
    logic [7:0] aux_in = 0, aux_out, din, a, q, sw, bd, av, wd;
    logic [7:3] board_req = 0;
    logic [7:0] msk = 8'h00;
    logic [7:0] addr, dout, vi_oe;
    logic rd, wr, inta, sel, wq, pint, rqo, cpr, slr, rc = 0, resp;
    int n_fail = 0, n_checks = 0, service_routine = 0;
    always #25 hclk = ~hclk;
    iobs_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(resp), .hrdata(hrdata), .bus_addr(addr), .bus_io_rd(rd),
        .bus_io_wr(wr), .bus_inta(inta), .bus_dout(dout), .bus_din_q(din),
        .board_sel_q(sel), .wait_req_q(wq), .aux_in(aux_in),
        .aux_stb(aux_stb), .aux_out_q(aux_out), .hs_latch_q(hs),
        .vi_req(vi_req), .board_req(board_req), .pint_oe_q(pint),
        .vi_oe_q(vi_oe), .controller_request_output(rqo),
        .reset_contact_input(rc), .cpu_reset_q(cpr), .slave_reset_q(slr));
    iobs_cpu_model u_cpu (.hclk(hclk), .bus_addr(addr), .bus_io_rd(rd),
        .bus_io_wr(wr), .bus_inta(inta), .bus_dout(dout), .bus_din_q(din));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // ahb single word; waits bounded, hready sampled at the edge
    task automatic ahb(input logic w, input logic [7:0] ad,
            input logic [31:0] d, output logic [31:0] o);
        int k;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0000_00, ad};
        hwrite <= w;
        // phase 0 holds the address, phase 1 the data
        for (int ph = 0; ph < 2; ph++) begin
            k = 0;
            do begin
                @(posedge hclk);
                k++;
            end while (hready !== 1'b1 && k < 20);
            if (hready !== 1'b1) begin
                n_fail++;
                wrap_up();
            end
            if (ph == 0) begin
                htrans <= 2'b00;
                hsel <= 1'b0;
                hwdata <= d;
            end
        end
        o = hrdata;
    endtask
    // model: lowest index eligible above the top level in service
    function automatic int pick();
        logic [7:0] rq;
        rq = {board_req, vi_req} & ~msk;
        for (int i = 0; i < 8; i++) begin
            if (service_routine[i])
                return 8;
            if (rq[i])
                return i;
        end
        return 8;
    endfunction
    task automatic wreq();
        int k;
        // let request lines pass the input and output registers
        repeat (3) @(posedge hclk);
        for (k = 0; k < 10 && rqo !== (pick() != 8); k++)
            @(negedge hclk);
        chk(rqo, pick() != 8);
        if (k == 10)
            wrap_up();
    endtask
    task automatic ack();
        int v;
        v = pick();
        u_cpu.cycle(3'b100, 8'h00, 8'h00, q);
        chk(q, {iobs_pkg::VEC_HI_RST, (v == 8) ? iobs_pkg::IDLE_VEC : 3'(v)});
        chk(wq, 1'b1);
        if (v != 8)
            service_routine[v] = 1;
    endtask
    task automatic eos();
        u_cpu.cycle(3'b010, 8'h4e, 8'h00, q);
        for (int i = 0; i < 8; i++)
            if (service_routine[i]) begin
                service_routine[i] = 0;
                break;
            end
        wreq();
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h6718bb57));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        // factory values and an unmapped offset
        ahb(0, iobs_pkg::ADDR_SW_OFS, 0, r);
        chk(r, 32'h0000_001b);
        ahb(0, iobs_pkg::BAUD_SW_OFS, 0, r);
        chk(r, 32'h0000_002f);
        ahb(0, iobs_pkg::STRAP_OFS, 0, r);
        chk(r, 32'h0000_0006);
        ahb(0, 8'h10, 0, r);
        chk(r, 32'h0000_0000);
        // random bases: all eight ports, baud port, a miss
        for (int t = 0; t < 4; t++) begin
            sw = 8'($urandom) & 8'h3f;
            bd = 8'($urandom);
            ahb(1, iobs_pkg::ADDR_SW_OFS, {24'h0, sw}, r);
            ahb(1, iobs_pkg::BAUD_SW_OFS, {24'h0, bd}, r);
            a = {~sw[1], ~sw[2], ~sw[3], ~sw[4], ~sw[5], 3'h0};
            for (int o = 0; o < 8; o++) begin
                u_cpu.cycle(3'b001, a + 8'(o), 8'h00, q);
                chk(sel, 1'b1);
                chk(wq, sw[0]);
                if (o == 1)
                    chk(q, bd & 8'h3f);
            end
            u_cpu.cycle(3'b001, a ^ 8'h08, 8'h00, q);
            chk({sel, wq}, 2'b00);
        end
        // strobe polarity, latch clears, loopback strap
        for (int p = 0; p < 2; p++) begin
            ahb(1, iobs_pkg::ADDR_SW_OFS, {24'h0, 2'(p * 3), 6'h1b}, r);
            aux_stb <= p ? 2'b00 : 2'b11;
            repeat (2) @(posedge hclk);
            u_cpu.cycle(3'b001, 8'h4b, 8'h00, q);
            u_cpu.cycle(3'b010, 8'h4b, 8'h00, q);
            chk(hs, 2'b00);
            av = 8'($urandom);
            wd = 8'($urandom);
            aux_in <= av;
            @(posedge hclk);
            aux_stb <= ~aux_stb;
            repeat (3) @(posedge hclk);
            chk(hs, 2'b11);
            u_cpu.cycle(3'b001, 8'h48, 8'h00, q);
            chk(q, 8'h03);
            ahb(1, iobs_pkg::STRAP_OFS, 32'h0000_0006 | p, r);
            u_cpu.cycle(3'b010, 8'h4b, wd, q);
            chk({hs, aux_out}, {2'b01, wd});
            u_cpu.cycle(3'b001, 8'h4b, 8'h00, q);
            chk(q, av);
            chk(aux_out, p ? av : wd);
            // the inactive edge must leave both latches clear
            aux_stb <= ~aux_stb;
            repeat (3) @(posedge hclk);
            chk(hs, 2'b00);
        end
        ahb(1, iobs_pkg::STRAP_OFS, 32'h0000_0006, r);
        // bank one hides bank zero ports, bank port reads anywhere
        u_cpu.cycle(3'b010, 8'h4f, 8'h01, q);
        u_cpu.cycle(3'b001, 8'h49, 8'h00, q);
        chk(q, 8'h00);
        u_cpu.cycle(3'b001, 8'h4f, 8'h00, q);
        chk(q, 8'h01);
        u_cpu.cycle(3'b010, 8'h4f, 8'h00, q);
        // master: preempt, block, end commands after source clear
        vi_req <= 3'b100;
        wreq();
        chk({pint, vi_oe}, 9'h100);
        ack();
        vi_req <= 3'b110;
        wreq();
        ack();
        board_req[5] <= 1'b1;
        repeat (3) @(posedge hclk);
        wreq();
        vi_req[1] <= 1'b0;
        eos();
        vi_req[2] <= 1'b0;
        eos();
        ack();
        board_req <= 0;
        eos();
        // masked request stays quiet, unmasked one is served
        u_cpu.cycle(3'b010, 8'h4d, 8'h20, q);
        msk = 8'h20;
        board_req[5] <= 1'b1;
        wreq();
        u_cpu.cycle(3'b001, 8'h4d, 8'h00, q);
        chk(q, 8'h20);
        u_cpu.cycle(3'b010, 8'h4d, 8'h00, q);
        msk = 8'h00;
        wreq();
        ack();
        u_cpu.cycle(3'b001, 8'h4e, 8'h00, q);
        chk(q, 8'h20);
        board_req <= 0;
        eos();
        // empty acknowledge falls back to the idle vector
        ack();
        // slave: no acknowledge answer, vectored line driven
        ahb(1, iobs_pkg::STRAP_OFS, 32'h0000_0030, r);
        board_req[4] <= 1'b1;
        wreq();
        chk({pint, vi_oe}, 9'h008);
        ahb(0, iobs_pkg::STATUS_OFS, 0, r);
        chk(r, 32'h0001_0010);
        chk(resp, 1'b0);
        u_cpu.cycle(3'b100, 8'h00, 8'h00, q);
        chk({q, sel, wq}, 10'h000);
        board_req <= 0;
        // reset contact fan-out
        rc <= 1'b1;
        repeat (3) @(posedge hclk);
        chk({cpr, slr}, 2'b11);
        rc <= 1'b0;
        repeat (3) @(posedge hclk);
        chk({cpr, slr}, 2'b00);
        wrap_up();
    end
endmodule
